// ==== hw/ocpwm_pkg.sv ====
// constants and types shared by the pwm compare channel
package ocpwm_pkg;
    localparam int         DATA_W            = 32;
    localparam int         ADDR_W            = 8;
    localparam int         CNT_W             = 16;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_ONE   = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO   = 8'h04;
    localparam logic [7:0] OFS_PRIMARY       = 8'h08;
    localparam logic [7:0] OFS_SECONDARY     = 8'h0C;
    localparam logic [7:0] OFS_PERIOD        = 8'h10;
    localparam logic [7:0] OFS_STATUS        = 8'h14;
    // control one fields
    localparam int         POS_IDLE_STOP     = 13;
    localparam int         POS_TBSEL         = 10;
    localparam int         POS_FLT_EN        = 7;
    localparam int         POS_FLT_STAT      = 4;
    localparam int         POS_TRIG_CLR      = 3;
    localparam int         POS_MODE          = 0;
    localparam logic [15:0] CTRL_ONE_WMASK   = 16'h3F8F;
    localparam logic [15:0] CTRL_ONE_RESET   = 16'h0000;
    // control two fields
    localparam int         POS_FLT_EXIT      = 15;
    localparam int         POS_FLT_LEVEL     = 14;
    localparam int         POS_TRIG_SEL      = 7;
    localparam int         POS_SYNC_SEL      = 0;
    localparam logic [15:0] CTRL_TWO_WMASK   = 16'hC09F;
    localparam logic [15:0] CTRL_TWO_RESET   = 16'h000C;
    localparam logic [4:0] SYNC_SELF         = 5'h1F;
    // time base select codes
    localparam logic [2:0] TB_TIMER2         = 3'h0;
    localparam logic [2:0] TB_TIMER3         = 3'h1;
    localparam logic [2:0] TB_TIMER4         = 3'h2;
    localparam logic [2:0] TB_TIMER5         = 3'h3;
    localparam logic [2:0] TB_TIMER1         = 3'h4;
    localparam logic [2:0] TB_PERIPH         = 3'h7;
    // mode codes
    localparam logic [2:0] MODE_OFF          = 3'h0;
    localparam logic [2:0] MODE_EDGE         = 3'h6;
    localparam logic [2:0] MODE_CENTER       = 3'h7;
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;
    typedef enum logic [1:0] {FAULT_CMP = 2'd2, FAULT_PINB = 2'd1, FAULT_PINA = 2'd0} fault_idx_t;
endpackage : ocpwm_pkg

// ==== hw/ocpwm_cfg_if.sv ====
// settings handed from the register slave to the waveform core
`timescale 1ns/1ps
interface ocpwm_cfg_if;
    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic [15:0] primary_compare_value;
    logic [15:0] secondary_compare_value;
    logic [15:0] period_value;
    logic [2:0]  fault_clear;
    logic [2:0]  fault_status;
    logic [15:0] time_base_count;
    modport regs (output ctrl_one, output ctrl_two, output primary_compare_value,
                  output secondary_compare_value, output period_value,
                  output fault_clear, input fault_status, input time_base_count);
    modport core (input ctrl_one, input ctrl_two, input primary_compare_value,
                  input secondary_compare_value, input period_value,
                  input fault_clear, output fault_status, output time_base_count);
endinterface : ocpwm_cfg_if

// ==== hw/ocpwm_regs.sv ====
// axi4-lite register slave for the pwm compare channel
`timescale 1ns/1ps
module ocpwm_regs
    import ocpwm_pkg::*;
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [ocpwm_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [ocpwm_pkg::ADDR_W-1:0] araddr,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    ocpwm_cfg_if.regs                         cfg
);
    logic [7:0]  aw_reg, aw_next;
    logic        awh_reg, awh_next, wh_reg, wh_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0]  ws_reg, ws_next;
    logic        bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next;
    logic [15:0] c1_reg, c1_next, c2_reg, c2_next;
    logic [15:0] pr_reg, pr_next, sc_reg, sc_next, per_reg, per_next;
    logic [2:0]  fc_reg, fc_next;
    logic        awr_reg, awr_next, wr_reg, wr_next, arr_reg, arr_next;

    // merge low half of a write under byte strobes and a writable mask
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (s[0]) v[7:0] = d[7:0];
        if (s[1]) v[15:8] = d[15:8];
        return (v & m) | (old & ~m);
    endfunction : merge

    always_comb begin
        aw_next = aw_reg; awh_next = awh_reg; wh_next = wh_reg;
        wd_next = wd_reg; ws_next = ws_reg; bv_next = bv_reg; br_next = br_reg;
        rv_next = rv_reg; rr_next = rr_reg; rd_next = rd_reg;
        c1_next = c1_reg; c2_next = c2_reg; pr_next = pr_reg;
        sc_next = sc_reg; per_next = per_reg; fc_next = 3'h0;
        if (awvalid && !awh_reg) begin
            aw_next = awaddr;
            awh_next = 1'b1;
        end
        if (wvalid && !wh_reg) begin
            wd_next = wdata;
            ws_next = wstrb;
            wh_next = 1'b1;
        end
        if (awh_reg && wh_reg && !bv_reg) begin
            awh_next = 1'b0;
            wh_next = 1'b0;
            bv_next = 1'b1;
            br_next = RESP_OKAY;
            if (aw_reg == OFS_CONTROL_ONE) begin
                c1_next = merge(c1_reg, wd_reg, ws_reg, CTRL_ONE_WMASK);
                // writing zero to a status bit clears it
                if (ws_reg[0]) fc_next = ~wd_reg[POS_FLT_STAT +: 3] & cfg.fault_status;
            end else if (aw_reg == OFS_CONTROL_TWO) begin
                c2_next = merge(c2_reg, wd_reg, ws_reg, CTRL_TWO_WMASK);
            end else if (aw_reg == OFS_PRIMARY) begin
                pr_next = merge(pr_reg, wd_reg, ws_reg, 16'hFFFF);
            end else if (aw_reg == OFS_SECONDARY) begin
                sc_next = merge(sc_reg, wd_reg, ws_reg, 16'hFFFF);
            end else if (aw_reg == OFS_PERIOD) begin
                per_next = merge(per_reg, wd_reg, ws_reg, 16'hFFFF);
            end else if (aw_reg != OFS_STATUS) begin
                br_next = RESP_SLVERR;
            end
        end
        if (bv_reg && bready) bv_next = 1'b0;
        if (arvalid && !rv_reg) begin
            rv_next = 1'b1;
            rr_next = RESP_OKAY;
            if (araddr == OFS_CONTROL_ONE) begin
                rd_next = {16'h0000, c1_reg | {9'h000, cfg.fault_status, 4'h0}};
            end else if (araddr == OFS_CONTROL_TWO) begin
                rd_next = {16'h0000, c2_reg};
            end else if (araddr == OFS_PRIMARY) begin
                rd_next = {16'h0000, pr_reg};
            end else if (araddr == OFS_SECONDARY) begin
                rd_next = {16'h0000, sc_reg};
            end else if (araddr == OFS_PERIOD) begin
                rd_next = {16'h0000, per_reg};
            end else if (araddr == OFS_STATUS) begin
                rd_next = {16'h0000, cfg.time_base_count};
            end else begin
                rd_next = 32'h0000_0000;
                rr_next = RESP_SLVERR;
            end
        end else if (rv_reg && rready) begin
            rv_next = 1'b0;
        end
        // ready flags registered so the bus outputs come straight from flops
        awr_next = !awh_next;
        wr_next = !wh_next;
        arr_next = !rv_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg <= 8'h00; awh_reg <= 1'b0; wh_reg <= 1'b0; wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0; bv_reg <= 1'b0; br_reg <= 2'h0; rv_reg <= 1'b0;
            rr_reg <= 2'h0; rd_reg <= 32'h0000_0000; c1_reg <= CTRL_ONE_RESET;
            c2_reg <= CTRL_TWO_RESET; pr_reg <= 16'h0000; sc_reg <= 16'h0000;
            per_reg <= 16'h0000; fc_reg <= 3'h0;
            awr_reg <= 1'b1; wr_reg <= 1'b1; arr_reg <= 1'b1;
        end else begin
            aw_reg <= aw_next; awh_reg <= awh_next; wh_reg <= wh_next; wd_reg <= wd_next;
            ws_reg <= ws_next; bv_reg <= bv_next; br_reg <= br_next; rv_reg <= rv_next;
            rr_reg <= rr_next; rd_reg <= rd_next; c1_reg <= c1_next; c2_reg <= c2_next;
            pr_reg <= pr_next; sc_reg <= sc_next; per_reg <= per_next; fc_reg <= fc_next;
            awr_reg <= awr_next; wr_reg <= wr_next; arr_reg <= arr_next;
        end
    end

    assign awready = awr_reg;
    assign wready  = wr_reg;
    assign bvalid  = bv_reg;
    assign bresp   = br_reg;
    assign arready = arr_reg;
    assign rvalid  = rv_reg;
    assign rresp   = rr_reg;
    assign rdata   = rd_reg;
    assign cfg.ctrl_one = c1_reg;
    assign cfg.ctrl_two = c2_reg;
    assign cfg.primary_compare_value = pr_reg;
    assign cfg.secondary_compare_value = sc_reg;
    assign cfg.period_value = per_reg;
    assign cfg.fault_clear = fc_reg;
endmodule : ocpwm_regs

// ==== hw/ocpwm_top.sv ====
// pwm mode of one output compare channel with axi4-lite registers
// Function
// RULE1 - makes edge or centre aligned pwm; settings go through hidden shadows; here both modes give the same primary to secondary window
// RULE2 - software loads duty into primary, period into secondary compare; here period has its own register, secondary match ends the pulse
// RULE3 - software selects self sync 0x1F and clears trigger select
// RULE4 - time base select bits 12:10 pick count clock; 110,101 reserved
// RULE5 - timer source counts on that timer's prescaler tick, not its output
// RULE6 - period value N gives N plus one counts
// RULE7 - duty values latch into working registers only at period match
// RULE8 - all three values zero keeps output low
// RULE9 - secondary compare above period keeps output high
// RULE10 - bit 13 set halts channel in idle; clear keeps running
// RULE11 - bits 9,8,7 arm comparator, second pin, first pin faults
// RULE12 - bit 6 comparator fault status, bit 5 second pin status
// RULE13 - fault enables and status act only in modes 111 or 110
// RULE14 - comparator fault shared by channel pairs
// RULE15 - software enables compare interrupt when using fault pins
// RULE16 - mode field: 111 centre, 110 edge, 101-001 compare, 000 off
// RULE17 - bit 4 shows a first pin fault occurred
// RULE18 - during fault output driven to fault output level
// RULE19 - fault ends on source removal plus new period or software clear
// RULE20 - counter restarts at period match; output switches at compare matches
// RULE21 - status set only when enabled, input active and pwm mode
`timescale 1ns/1ps
module ocpwm_top
    import ocpwm_pkg::*;
#(
    parameter int CHANNEL = 1
)
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [ocpwm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [ocpwm_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic [4:0]                   timer_prescale_tick,
    input  wire logic                         cpu_idle,
    input  wire logic [2:0]                   comparator_out,
    input  wire logic                         first_fault_pin,
    input  wire logic                         second_fault_pin,
    output logic                              compare_output_pin,
    output logic                              fault_active
);
    ocpwm_cfg_if cfg ();

    ocpwm_regs u_regs (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .cfg     (cfg.regs)
    );

    logic [2:0]  channel_mode_select;
    logic [2:0]  time_base_select;
    logic [2:0]  fault_input_enables;
    logic        idle_stop_control;
    logic        fault_output_level;
    logic        fault_exit_mode;
    logic        pwm_mode;
    logic        tick;
    logic        run;
    logic        period_match;
    logic [2:0]  fault_in;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] duty_a_reg, duty_a_next, duty_b_reg, duty_b_next;
    logic [15:0] per_w_reg, per_w_next;
    logic        out_reg, out_next;
    logic        wave;
    logic [2:0]  fstat_reg, fstat_next;
    logic        flt_reg, flt_next;

    assign channel_mode_select = cfg.ctrl_one[POS_MODE +: 3];
    assign time_base_select    = cfg.ctrl_one[POS_TBSEL +: 3];
    assign fault_input_enables = cfg.ctrl_one[POS_FLT_EN +: 3];
    assign idle_stop_control   = cfg.ctrl_one[POS_IDLE_STOP];
    assign fault_output_level  = cfg.ctrl_two[POS_FLT_LEVEL];
    assign fault_exit_mode     = cfg.ctrl_two[POS_FLT_EXIT];
    // only the two pwm codes count as pwm
    assign pwm_mode = (channel_mode_select == MODE_EDGE) ||
                      (channel_mode_select == MODE_CENTER); // RULE16 RULE13

    // count clock choice; reserved codes never tick
    always_comb begin
        case (time_base_select)
            TB_PERIPH: tick = 1'b1; // RULE4
            TB_TIMER1: tick = timer_prescale_tick[0]; // RULE5
            TB_TIMER2: tick = timer_prescale_tick[1];
            TB_TIMER3: tick = timer_prescale_tick[2];
            TB_TIMER4: tick = timer_prescale_tick[3];
            TB_TIMER5: tick = timer_prescale_tick[4];
            default:   tick = 1'b0;
        endcase
    end

    assign run = pwm_mode && tick && !(idle_stop_control && cpu_idle); // RULE10
    assign period_match = (cnt_reg == per_w_reg); // RULE6

    // pair comparator: channels 1-2 use 0, 3-4 use 1, 5-6 use 2
    localparam int CMP_IDX = (CHANNEL - 1) / 2;
    assign fault_in = {comparator_out[CMP_IDX], second_fault_pin, first_fault_pin}; // RULE14

    always_comb begin
        cnt_next = cnt_reg;
        duty_a_next = duty_a_reg;
        duty_b_next = duty_b_reg;
        per_w_next = per_w_reg;
        if (!pwm_mode) begin
            // idle channel tracks software values so first period is right
            cnt_next = 16'h0000;
            duty_a_next = cfg.primary_compare_value;
            duty_b_next = cfg.secondary_compare_value;
            per_w_next = cfg.period_value;
        end else if (run) begin
            if (period_match) begin
                cnt_next = 16'h0000; // RULE20
                duty_a_next = cfg.primary_compare_value; // RULE7 RULE1
                duty_b_next = cfg.secondary_compare_value; // RULE7
                per_w_next = cfg.period_value;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    // waveform from working values; high between primary and secondary match
    always_comb begin
        if (duty_b_reg > per_w_reg) begin
            wave = 1'b1; // RULE9
        end else if (channel_mode_select == MODE_CENTER) begin
            wave = (cnt_reg >= duty_a_reg) && (cnt_reg < duty_b_reg); // RULE20
        end else begin
            // all zero gives empty window, so output stays low
            wave = (cnt_reg >= duty_a_reg) && (cnt_reg < duty_b_reg); // RULE8
        end
    end

    always_comb begin
        fstat_next = fstat_reg & ~cfg.fault_clear;
        // set wins over a software clear in the same cycle
        if (pwm_mode) begin
            fstat_next = fstat_next | (fault_in & fault_input_enables); // RULE21 RULE11 RULE12 RULE17
        end
        flt_next = flt_reg;
        if (pwm_mode && |(fault_in & fault_input_enables)) begin
            flt_next = 1'b1;
        end else if (!fault_exit_mode) begin
            if (run && period_match) flt_next = 1'b0; // RULE19
        end else if (fstat_next == 3'h0) begin
            flt_next = 1'b0; // RULE19
        end
        if (!pwm_mode) flt_next = 1'b0; // RULE13
        out_next = flt_next ? fault_output_level : (pwm_mode && wave); // RULE18
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 16'h0000;
            duty_a_reg <= 16'h0000;
            duty_b_reg <= 16'h0000;
            per_w_reg <= 16'h0000;
            fstat_reg <= 3'h0;
            flt_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            duty_a_reg <= duty_a_next;
            duty_b_reg <= duty_b_next;
            per_w_reg <= per_w_next;
            fstat_reg <= fstat_next;
            flt_reg <= flt_next;
            out_reg <= out_next;
        end
    end

    assign cfg.fault_status = fstat_reg;
    assign cfg.time_base_count = cnt_reg;
    assign compare_output_pin = out_reg;
    assign fault_active = flt_reg;

    a_period_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
        pwm_mode && run && period_match |=> cnt_reg == 16'h0000)
        else $error("counter did not restart at period match");
    a_duty_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        pwm_mode && $past(pwm_mode) && !(run && period_match) |=> $stable(duty_b_reg))
        else $error("duty changed outside period match");
    a_full_high: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
        pwm_mode && !flt_next && duty_b_reg > per_w_reg |=> compare_output_pin)
        else $error("output not high with secondary above period");
    a_zero_low: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        pwm_mode && !flt_next && duty_a_reg == 16'h0 && duty_b_reg == 16'h0
        && per_w_reg == 16'h0 |=> !compare_output_pin)
        else $error("output not low with all zero");
    a_fault_level: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
        fault_active |-> compare_output_pin == $past(fault_output_level))
        else $error("fault output level wrong");
    a_fault_set: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
        pwm_mode && fault_in[0] && fault_input_enables[0] |=> fstat_reg[0])
        else $error("first pin fault not recorded");
    a_no_pwm_flt: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        !pwm_mode |=> !fault_active && ((fstat_reg & ~$past(fstat_reg)) == 3'h0))
        else $error("fault acted outside pwm mode");
    a_idle_halt: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        pwm_mode && $past(pwm_mode) && idle_stop_control && cpu_idle |=> $stable(cnt_reg))
        else $error("counter moved in idle");
    a_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        pwm_mode && run && !period_match |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter step wrong");
endmodule : ocpwm_top

// ==== verif/ocpwm_far_side.sv ====
// far side model: timer prescaler ticks and fault sources
`timescale 1ns/1ps
module ocpwm_far_side (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] fault_req,
    output logic      [4:0] timer_prescale_tick,
    output logic      [2:0] comparator_out,
    output logic            first_fault_pin,
    output logic            second_fault_pin
);
    logic [7:0] cyc_reg;
    always_ff @(posedge aclk) begin
        cyc_reg <= aresetn ? cyc_reg + 8'h01 : 8'h00;
    end
    // distinct rates per timer so a wrong select shows up
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            timer_prescale_tick[i] = ((cyc_reg % (i + 2)) == 0);
        end
    end
    assign comparator_out   = {2'b00, fault_req[2]};
    assign first_fault_pin  = fault_req[0];
    assign second_fault_pin = fault_req[1];
endmodule : ocpwm_far_side

// ==== verif/output_compare_pwm_mode_test.sv ====
// self-checking bench for the pwm compare channel
`timescale 1ns/1ps
module output_compare_pwm_mode_test;
    import ocpwm_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_idle;
    logic        awready, wready, bvalid, arready, rvalid, pin, flt;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp;
    logic [4:0]  tick;
    logic [2:0]  cmp, fault_req;
    logic        fa, fb;
    int          mismatches, samples_checked;
    initial begin
        aclk = 0;
        forever #12.5 aclk = ~aclk;
    end
    ocpwm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_prescale_tick(tick), .cpu_idle(cpu_idle),
        .comparator_out(cmp), .first_fault_pin(fa), .second_fault_pin(fb),
        .compare_output_pin(pin), .fault_active(flt));
    ocpwm_far_side far (.aclk(aclk), .aresetn(aresetn), .fault_req(fault_req),
        .timer_prescale_tick(tick), .comparator_out(cmp), .first_fault_pin(fa),
        .second_fault_pin(fb));
    task automatic end_of_test;
        if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            $display("CHECK FAILED at %0t: %s", $time, m);
            mismatches++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        awaddr <= a; awvalid <= 1; wdata <= {16'h0000, d}; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
        @(posedge aclk);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rready <= 0;
        @(posedge aclk);
    endtask : rdr
    // program duty, period, self sync, then the given mode on the peripheral clock
    task automatic duty(input logic [15:0] p, s, per, input logic [2:0] m, output int h);
        wr(OFS_PRIMARY, p);
        wr(OFS_SECONDARY, s);
        wr(OFS_PERIOD, per);
        wr(OFS_CONTROL_TWO, 16'h401F);
        wr(OFS_CONTROL_ONE, {13'h0380, m});
        repeat (24) @(posedge aclk);
        h = 0;
        repeat (16) @(posedge aclk) h += int'(pin);
    endtask : duty
    task automatic test_regs;
        rdr(OFS_CONTROL_ONE);
        chk(rd === 32'h00000000, "control one reset");
        rdr(OFS_CONTROL_TWO);
        chk(rd === 32'h0000000C, "control two reset");
        rdr(8'h3C);
        chk(rresp === RESP_SLVERR && rd === 32'h00000000, "unmapped read");
    endtask : test_regs
    task automatic test_waves;
        int h;
        duty(16'h0002, 16'h0005, 16'h0007, MODE_EDGE, h);
        chk(h == 6, "edge duty over two periods");
        duty(16'h0002, 16'h0005, 16'h0007, MODE_CENTER, h);
        chk(h == 6, "centre duty over two periods");
        duty(16'h0000, 16'h0000, 16'h0000, MODE_EDGE, h);
        chk(h == 0, "zero duty");
        duty(16'h0000, 16'h0009, 16'h0007, MODE_EDGE, h);
        chk(h == 16, "full duty");
    endtask : test_waves
    task automatic test_fault;
        duty(16'h0000, 16'h0000, 16'h0000, MODE_EDGE, rd);
        wr(OFS_CONTROL_ONE, 16'h1C86);
        fault_req <= 3'b111;
        repeat (4) @(posedge aclk);
        chk(pin === 1'b1 && flt === 1'b1, "fault drives level");
        rdr(OFS_CONTROL_ONE);
        chk(rd[6:4] === 3'b001, "first pin status");
        fault_req <= 3'b000;
        repeat (4) @(posedge aclk);
        chk(flt === 1'b0, "fault exit at period");
        wr(OFS_CONTROL_ONE, 16'h1C86);
        rdr(OFS_CONTROL_ONE);
        chk(rd[6:4] === 3'b000, "status cleared");
        wr(OFS_CONTROL_ONE, 16'h1F80);
        fault_req <= 3'b111;
        repeat (4) @(posedge aclk);
        rdr(OFS_CONTROL_ONE);
        chk(rd[6:4] === 3'b000 && flt === 1'b0, "faults outside pwm");
        wr(OFS_CONTROL_ONE, 16'h1F86);
        repeat (4) @(posedge aclk);
        rdr(OFS_CONTROL_ONE);
        chk(rd[6:4] === 3'b111, "all fault status");
        fault_req <= 3'b000;
    endtask : test_fault
    task automatic test_clock;
        logic [15:0] c0;
        cpu_idle <= 1;
        wr(OFS_PERIOD, 16'hFFFF);
        wr(OFS_CONTROL_ONE, {3'b000, TB_TIMER2, 7'h00, MODE_EDGE});
        rdr(OFS_STATUS);
        c0 = rd[15:0];
        repeat (45) @(posedge aclk);
        rdr(OFS_STATUS);
        chk(rd[15:0] - c0 >= 16'd14 && rd[15:0] - c0 <= 16'd18, "timer tick rate");
        wr(OFS_CONTROL_ONE, {3'b001, TB_TIMER2, 7'h00, MODE_EDGE});
        rdr(OFS_STATUS);
        c0 = rd[15:0];
        repeat (30) @(posedge aclk);
        rdr(OFS_STATUS);
        chk(rd[15:0] === c0, "idle stop halts");
        cpu_idle <= 0;
    endtask : test_clock
    initial begin
        aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; cpu_idle = 0; fault_req = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        test_regs();
        test_waves();
        test_fault();
        test_clock();
        end_of_test();
    end
    // hang guard, far above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end
endmodule : output_compare_pwm_mode_test
